// ==== cfdr_cfg.svh ====
// Constants for the clock failure detect and recovery block.
// Assumes a 20 MHz system clock; included by bare name.
`ifndef CFDR_CFG_SVH
`define CFDR_CFG_SVH
// Clock rate and nominal primary failure threshold.
`define CFDR_CLK_HZ          20000000
`define CFDR_PRI_MIN_HZ      1000
// Watchdog oscillator failure count in system clocks.
`define CFDR_WDT_FAIL_CYCLES 8004
// Primary check window: one nominal threshold period in reference ticks.
`define CFDR_REF_HZ          1000000
`define CFDR_PRI_WIN_TICKS   (`CFDR_REF_HZ / `CFDR_PRI_MIN_HZ)
// Clock source select encodings.
`define CFDR_SRC_PRIMARY     2'h0
`define CFDR_SRC_WATCHDOG    2'h1
`endif

// ==== cfdr_core_model.sv ====
// Core model: takes failure events and acknowledges the flags.
// Assumes the cfdr_top core-side ports.
`timescale 1ns/1ps
`default_nettype none
module cfdr_core_model (
  input  wire logic       mclk_i, rst_i, pri_evt_i, wdt_evt_i, pri_flag_i, wdt_flag_i,
  output var  logic       fail_ack_o = 1'b0,
  output var  logic [1:0] n_pri, n_wdt
);
  // The handler answers a flag on the next falling edge, half a cycle after it rises, then lets go.
  always @(negedge mclk_i) fail_ack_o <= !rst_i && (pri_flag_i || wdt_flag_i) && !fail_ack_o;
  always @(posedge mclk_i) begin
    if (rst_i) begin
      n_pri <= 2'h0;
      n_wdt <= 2'h0;
    end else begin
      n_pri <= n_pri + {1'b0, pri_evt_i};
      n_wdt <= n_wdt + {1'b0, wdt_evt_i};
    end
  end
endmodule
`default_nettype wire

// ==== cfdr_monitor.sv ====
// Port checker for cfdr_top.
// Assumes a bind onto cfdr_top and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module cfdr_monitor #(
  parameter int unsigned WDT_FAIL_CYCLES = 20
) (
  input wire logic       mclk_i, rst_i, wdt_osc_i, wdt_osc_fail_detect_en_i,
  input wire logic       wdt_osc_enabled_i, wdt_reset_mode_i,
  input wire logic [1:0] clock_source_select_i,
  input wire logic       pri_fail_evt_o, wdt_fail_evt_o, pri_fail_flag_o,
  input wire logic       wdt_fail_flag_o, force_wdt_clk_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // ---
  // Helper state
  // ---
  // Quiet time restarts on the raw oscillator level, two cycles before the design's synchronised count, so it runs ahead of it.
  logic [15:0] quiet_r;
  logic        wdt_seen_r;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      quiet_r    <= 16'h0000;
      wdt_seen_r <= 1'b0;
    end else begin
      quiet_r    <= ($changed(wdt_osc_i) || !wdt_osc_fail_detect_en_i) ? 16'h0000 : quiet_r + 16'h0001;
      wdt_seen_r <= wdt_seen_r | wdt_fail_evt_o;
    end
  end
  a_pri_evt_flag: assert property (pri_fail_evt_o |-> pri_fail_flag_o) else $error("pri flag");
  a_pri_evt_pulse: assert property (pri_fail_evt_o |=> !pri_fail_evt_o) else $error("pri pulse");
  a_force_held: assert property (force_wdt_clk_o |=> force_wdt_clk_o) else $error("force drop");
  a_switch_osc_on: assert property ($rose(force_wdt_clk_o) |-> $past(wdt_osc_enabled_i)) else $error("osc off");
  a_switch_src: assert property ($rose(force_wdt_clk_o) |-> $past(clock_source_select_i) != 2'h1) else $error("src");
  a_switch_rst_mode: assert property ($rose(force_wdt_clk_o) |-> !$past(wdt_reset_mode_i)) else $error("rmode");
  a_wdt_no_switch: assert property (wdt_fail_evt_o |-> wdt_fail_flag_o && !$rose(force_wdt_clk_o)) else $error("wsw");
  a_pri_lock: assert property (wdt_seen_r |-> !pri_fail_evt_o) else $error("pri after wdt");
  a_wdt_idle: assert property (!wdt_osc_enabled_i && $past(wdt_osc_enabled_i, 2) == 1'b0 |-> !wdt_fail_evt_o)
    else $error("wdt idle");
  a_wdt_count: assert property (wdt_fail_evt_o |-> quiet_r >= WDT_FAIL_CYCLES) else $error("wdt early");
endmodule
`default_nettype wire

// ==== cfdr_pkg.sv ====
// Types shared by the clock failure detect and recovery modules.
// Assumes cfdr_cfg.svh supplies the numbers.
package cfdr_pkg;
  typedef enum logic [1:0] {
    CFDR_RUN     = 2'b00,
    CFDR_PRI_BAD = 2'b01,
    CFDR_WDT_BAD = 2'b11
  } cfdr_state_t;
endpackage

// ==== cfdr_tb.sv ====
// Testbench for cfdr_top with a core model on the event side.
// Assumes short counts: 20 cycles watchdog, one tick primary window.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, rst = 1, tick = 0, wosc = 0, pen = 0, wen = 0, oen = 1, rmd = 0, fast = 0, wrun = 1;
  logic [1:0] src = 2'h0;
  logic ack, pe, we, pf, wf, frc;
  int n_fail = 0, total_checks = 0, tc = 0;
  always #25 clk = ~clk;
  // ---
  // Stimulus sources
  // ---
  always @(negedge clk) begin
    tc <= (tc == 19) ? 0 : tc + 1;
    tick <= fast | (tc == 0);
    if (wrun && tc % 5 == 0) wosc <= ~wosc;
  end
  cfdr_top #(.WDT_FAIL_CYCLES(20), .PRI_WIN_TICKS(1)) dut (.mclk_i(clk), .rst_i(rst), .ref_tick_i(tick),
    .wdt_osc_i(wosc), .primary_fail_detect_en_i(pen), .wdt_osc_fail_detect_en_i(wen), .wdt_osc_enabled_i(oen),
    .wdt_reset_mode_i(rmd), .clock_source_select_i(src), .fail_ack_i(ack), .pri_fail_evt_o(pe),
    .wdt_fail_evt_o(we), .pri_fail_flag_o(pf), .wdt_fail_flag_o(wf), .force_wdt_clk_o(frc));
  cfdr_core_model core (.mclk_i(clk), .rst_i(rst), .pri_evt_i(pe), .wdt_evt_i(we), .pri_flag_i(pf),
    .wdt_flag_i(wf), .fail_ack_o(ack), .n_pri(), .n_wdt());
  task automatic chk(string nm, logic [1:0] got, logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic watch(int n, output logic p, output logic w);
    p = 0;
    w = 0;
    repeat (n) begin
      @(negedge clk);
      p |= pe;
      w |= we;
    end
  endtask
  task automatic rst_dut;
    rst = 1;
    repeat (12) @(negedge clk);
    // Release away from a reference tick, so the primary window has seen clocks first.
    do @(negedge clk); while (tc != 5);
    rst = 0;
  endtask
  task automatic t_wdt;
    logic p, w;
    rst_dut();
    pen = 1; wen = 1; oen = 1; src = 2'h0; wrun = 1;
    watch(80, p, w); chk("wdt_quiet", w, 0);
    wrun = 0; watch(14, p, w); chk("wdt_early", w, 0);
    watch(20, p, w); chk("wdt_evt", w, 1);
    chk("wdt_noswitch", frc, 0);
    fast = 1; watch(40, p, w); chk("pri_locked", p, 0);
    chk("wdt_count", core.n_wdt, 1);
    chk("wdt_acked", wf, 0);
    fast = 0; wrun = 1;
    $display("t_wdt done");
  endtask
  task automatic t_pri(logic e, logic o, logic [1:0] s, logic r, logic f);
    logic p, w;
    rst_dut();
    wen = 0; pen = e; oen = o; src = s; rmd = r;
    watch(100, p, w); chk("pri_quiet", p, 0);
    fast = 1; watch(40, p, w); chk("pri_evt", p, e);
    chk("force", frc, f);
    chk("pri_count", core.n_pri, {1'b0, e});
    chk("pri_acked", pf, 0);
    fast = 0;
    $display("t_pri %0b%0b%0h%0b done", e, o, s, r);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    t_wdt();
    t_pri(1, 1, 2'h0, 0, 1);
    t_pri(1, 0, 2'h0, 0, 0);
    t_pri(1, 1, 2'h1, 0, 0);
    t_pri(1, 1, 2'h0, 1, 0);
    t_pri(0, 1, 2'h0, 0, 0);
    wrap_up();
  end
  initial begin
    #200us;
    n_fail++;
    wrap_up();
  end
endmodule
bind cfdr_top cfdr_monitor #(.WDT_FAIL_CYCLES(WDT_FAIL_CYCLES)) u_mon (.mclk_i, .rst_i, .wdt_osc_i,
  .wdt_osc_fail_detect_en_i, .wdt_osc_enabled_i, .wdt_reset_mode_i, .clock_source_select_i, .pri_fail_evt_o,
  .wdt_fail_evt_o, .pri_fail_flag_o, .wdt_fail_flag_o, .force_wdt_clk_o);
`default_nettype wire

// ==== cfdr_top.sv ====
// Clock failure detection and recovery: primary and watchdog oscillator checks.
// Assumes one system clock; ref_tick_i is a 1 MHz enable from an independent
// reference, used to measure how fast the system clock is running.
`timescale 1ns/1ps
`default_nettype none
`include "cfdr_cfg.svh"
module cfdr_top #(
  parameter int unsigned WDT_FAIL_CYCLES = `CFDR_WDT_FAIL_CYCLES,
  parameter int unsigned PRI_WIN_TICKS   = `CFDR_PRI_WIN_TICKS
) (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // Oscillator observation
  input  wire logic       ref_tick_i,
  input  wire logic       wdt_osc_i,
  // Oscillator control settings
  input  wire logic       primary_fail_detect_en_i,
  input  wire logic       wdt_osc_fail_detect_en_i,
  input  wire logic       wdt_osc_enabled_i,
  input  wire logic       wdt_reset_mode_i,
  input  wire logic [1:0] clock_source_select_i,
  // Core side
  input  wire logic       fail_ack_i,
  output var  logic       pri_fail_evt_o,
  output var  logic       wdt_fail_evt_o,
  output var  logic       pri_fail_flag_o,
  output var  logic       wdt_fail_flag_o,
  output var  logic       force_wdt_clk_o
);
  // ---------------------------------------------------------------
  // Primary clock frequency check
  // ---------------------------------------------------------------
  // A window of PRI_WIN_TICKS reference ticks lasts one nominal threshold
  // period. If the system clock gives fewer than two edges in it, the clock
  // is below the threshold; a stalled clock is caught by the tick logic
  // itself running off the reference, which is outside this block.
  localparam int PW = $clog2(PRI_WIN_TICKS + 1);

  cfdr_wdt_if wif ();

  logic [PW-1:0]       win_r, win_nxt;
  logic [1:0]          clks_r, clks_nxt;
  logic                pri_bad;
  cfdr_pkg::cfdr_state_t st_r, st_nxt;
  logic                pri_evt_nxt, wdt_evt_nxt;
  logic                pri_flag_nxt, wdt_flag_nxt, force_nxt;
  logic                wdt_is_src, can_switch, wdt_check_ok;

  assign wdt_is_src   = (clock_source_select_i == `CFDR_SRC_WATCHDOG);
  assign can_switch   = wdt_osc_enabled_i && !wdt_is_src && !wdt_reset_mode_i;
  assign wdt_check_ok = wdt_osc_fail_detect_en_i && wdt_osc_enabled_i && !wdt_is_src;
  assign wif.arm      = wdt_check_ok && (st_r != cfdr_pkg::CFDR_WDT_BAD);

  cfdr_wdt_mon #(
    .FAIL_CYCLES (WDT_FAIL_CYCLES)
  ) u_wdt_mon (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .wdt_osc_i (wdt_osc_i),
    .ctl       (wif.mon)
  );

  always_comb begin
    win_nxt  = win_r;
    clks_nxt = clks_r;
    pri_bad  = 1'b0;
    if (!primary_fail_detect_en_i) begin
      win_nxt  = '0;
      clks_nxt = '0;
    end else if (ref_tick_i) begin
      if (win_r == PW'(PRI_WIN_TICKS - 1)) begin
        pri_bad  = (clks_r < 2'd2);
        win_nxt  = '0;
        clks_nxt = '0;
      end else begin
        win_nxt  = win_r + PW'(1);
        clks_nxt = (clks_r == 2'd3) ? clks_r : clks_r + 2'd1;
      end
    end else begin
      clks_nxt = (clks_r == 2'd3) ? clks_r : clks_r + 2'd1;
    end
  end

  // ---------------------------------------------------------------
  // Failure state and recovery
  // ---------------------------------------------------------------
  // Once the watchdog oscillator is lost the primary check is frozen,
  // because the only fallback clock is gone.
  always_comb begin
    st_nxt       = st_r;
    pri_evt_nxt  = 1'b0;
    wdt_evt_nxt  = 1'b0;
    pri_flag_nxt = pri_fail_flag_o;
    wdt_flag_nxt = wdt_fail_flag_o;
    force_nxt    = force_wdt_clk_o;
    if (fail_ack_i) begin
      pri_flag_nxt = 1'b0;
      wdt_flag_nxt = 1'b0;
    end
    case (st_r)
      cfdr_pkg::CFDR_RUN: begin
        if (wif.fail) begin
          st_nxt       = cfdr_pkg::CFDR_WDT_BAD;
          wdt_evt_nxt  = 1'b1;
          wdt_flag_nxt = 1'b1;
        end else if (pri_bad) begin
          st_nxt       = cfdr_pkg::CFDR_PRI_BAD;
          pri_evt_nxt  = 1'b1;
          pri_flag_nxt = 1'b1;
          force_nxt    = can_switch;
        end
      end
      cfdr_pkg::CFDR_PRI_BAD: begin
        if (wif.fail) begin
          st_nxt       = cfdr_pkg::CFDR_WDT_BAD;
          wdt_evt_nxt  = 1'b1;
          wdt_flag_nxt = 1'b1;
        end
      end
      cfdr_pkg::CFDR_WDT_BAD: begin
        st_nxt = cfdr_pkg::CFDR_WDT_BAD;
      end
      default: begin
        st_nxt = cfdr_pkg::CFDR_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      win_r           <= '0;
      clks_r          <= '0;
      st_r            <= cfdr_pkg::CFDR_RUN;
      pri_fail_evt_o  <= 1'b0;
      wdt_fail_evt_o  <= 1'b0;
      pri_fail_flag_o <= 1'b0;
      wdt_fail_flag_o <= 1'b0;
      force_wdt_clk_o <= 1'b0;
    end else begin
      win_r           <= win_nxt;
      clks_r          <= clks_nxt;
      st_r            <= st_nxt;
      pri_fail_evt_o  <= pri_evt_nxt;
      wdt_fail_evt_o  <= wdt_evt_nxt;
      pri_fail_flag_o <= pri_flag_nxt;
      wdt_fail_flag_o <= wdt_flag_nxt;
      force_wdt_clk_o <= force_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== cfdr_wdt_if.sv ====
// Interface between the top block and the watchdog oscillator monitor.
// Assumes a single system clock domain.
`timescale 1ns/1ps
`default_nettype none
interface cfdr_wdt_if;
  logic arm;
  logic fail;
  modport mon (input arm, output fail);
  modport top (output arm, input fail);
endinterface
`default_nettype wire

// ==== cfdr_wdt_mon.sv ====
// Watchdog oscillator monitor: counts system clocks between watchdog edges.
// Assumes the watchdog oscillator level is asynchronous; it is synchronised on mclk_i through s1_r and s2_r here.
`timescale 1ns/1ps
`default_nettype none
`include "cfdr_cfg.svh"
module cfdr_wdt_mon #(
  parameter int unsigned FAIL_CYCLES = `CFDR_WDT_FAIL_CYCLES
) (
  // Clock and reset
  input  wire logic    mclk_i,
  input  wire logic    rst_i,
  // Watchdog oscillator level
  input  wire logic    wdt_osc_i,
  // Control and result
  cfdr_wdt_if.mon      ctl
);
  localparam int CW = $clog2(FAIL_CYCLES + 1);

  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          s1_r, s2_r, s3_r;
  logic          fail_r, fail_nxt;
  logic          edge_seen;

  assign edge_seen = s2_r ^ s3_r;
  assign ctl.fail  = fail_r;

  always_comb begin
    cnt_nxt  = cnt_r;
    fail_nxt = fail_r;
    if (!ctl.arm) begin
      cnt_nxt = '0;
    end else if (edge_seen) begin
      cnt_nxt = '0;
    end else if (!fail_r) begin
      if (cnt_r == CW'(FAIL_CYCLES - 1)) begin
        fail_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + CW'(1);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_r  <= '0;
      fail_r <= 1'b0;
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      s3_r   <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      fail_r <= fail_nxt;
      s1_r   <= wdt_osc_i;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
    end
  end
endmodule
`default_nettype wire
